/* bench/pad_model.sv */
/* pad model: a pad follows its driver, else its pull, else floats.
   assumes registered pad controls from the port block on aclk. */
`timescale 1ns/1ps
module pad_model (
    input  wire        aclk,      // bus clock
    input  wire [55:0] pin_out,   // pad output levels
    input  wire [55:0] pin_oe,    // pad output enables
    input  wire [55:0] pull_up,   // pullups on
    input  wire [55:0] pull_down, // pulldowns on
    output wire [55:0] pin_in     // resolved pad levels
);
    reg float_lvl = 1'b0;
    // a floating pad flips each cycle so no stale level reads back
    always @(posedge aclk) begin
        float_lvl <= ~float_lvl;
    end
    // driver wins, then the pull, then the float pattern
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pull_up | (~pull_down & {56{float_lvl}})));
endmodule

/* bench/pin_port_ctrl_checker.sv */
/* checker for the pin port control block: ownership, pulls, sync delay.
   assumes a bind onto pin_port_ctrl and its single clock. */
`timescale 1ns/1ps
module pin_port_ctrl_checker #(
    parameter NPIN = 56
) (
    input wire            aclk,         // bus clock
    input wire            aresetn,      // sync reset, active low
    input wire            s_arvalid,    // read address valid
    input wire            s_arready,    // read address ready
    input wire            s_rvalid,     // read data valid
    input wire [7:0]      kbi_pin_en,   // keyboard owns port a
    input wire [3:0]      kbi_rising,   // keyboard rising select
    input wire [7:0]      adc_pin_en,   // converter owns port b
    input wire [NPIN-1:0] periph_oe,    // peripheral enables
    input wire [NPIN-1:0] pin_in,       // pad levels
    input wire [NPIN-1:0] periph_in,    // synced pad levels
    input wire [NPIN-1:0] pin_oe,       // pad enables
    input wire [NPIN-1:0] pull_up,      // pullups
    input wire [NPIN-1:0] pull_down,    // pulldowns
    input wire            irq_pin,      // irq pad
    input wire            irq_request,  // gated irq
    input wire            irq_pull_up,  // irq pullup
    input wire            irq_pull_down // irq pulldown
);
    reg [1:0] up;
    // edges since reset, so $past never looks into reset
    always @(posedge aclk) begin
        if (!aresetn) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_quiet: assert property ($rose(aresetn) |-> ~|{pin_oe, pull_up, pull_down, irq_pull_up})
        else $error("pins active after reset");
    a_kbi_owns_oe: assert property (kbi_pin_en[0] |=> pin_oe[0] == $past(periph_oe[0]))
        else $error("keyboard enable not on pad");
    a_adc_owns_oe: assert property (adc_pin_en[7] |=> pin_oe[15] == $past(periph_oe[15]))
        else $error("converter enable not on pad");
    a_pull_only_in: assert property (~|(pin_oe & (pull_up | pull_down)))
        else $error("pull on a driven pad");
    a_kbi_rise_down: assert property (kbi_pin_en[4] && kbi_rising[0] && !periph_oe[4] |=> pull_down[4] && !pull_up[4])
        else $error("rising keyboard pin not pulled down");
    a_kbi_fall_up: assert property (kbi_pin_en[5] && !kbi_rising[1] && !periph_oe[5] |=> pull_up[5] && !pull_down[5])
        else $error("falling keyboard pin not pulled up");
    a_irq_pull_one: assert property (!(irq_pull_up && irq_pull_down))
        else $error("irq pulled both ways");
    a_irq_from_pad: assert property (up == 2'h3 && irq_request |-> $past(irq_pin, 3))
        else $error("irq request without pad level");
    a_pad_sync: assert property (up == 2'h3 |-> periph_in == $past(pin_in, 2))
        else $error("pad level not two edges late");
    a_read_latency: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
endmodule
bind pin_port_ctrl pin_port_ctrl_checker #(.NPIN(NPIN)) chk (.aclk(aclk), .aresetn(aresetn), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rvalid(s_rvalid), .kbi_pin_en(kbi_pin_en), .kbi_rising(kbi_rising),
    .adc_pin_en(adc_pin_en), .periph_oe(periph_oe), .pin_in(pin_in), .periph_in(periph_in), .pin_oe(pin_oe),
    .pull_up(pull_up), .pull_down(pull_down), .irq_pin(irq_pin), .irq_request(irq_request),
    .irq_pull_up(irq_pull_up), .irq_pull_down(irq_pull_down));

/* bench/test_shared_pin_port_control.sv */
/* bench for pin_port_ctrl: axi4-lite tasks and pin scenarios.
   assumes pad_model and the checker are compiled first. */
`timescale 1ns/1ps
`include "pin_port_defs.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) miss(a, b); end
module test_shared_pin_port_control;
    reg         aclk = 1'b0, aresetn = 1'b0, irq_pin = 1'b0;
    reg         s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    reg         iic_en, sci2_en, spi_en, sci1_en, osc_en, debug_en;
    reg  [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, kbi_pin_en, adc_pin_en, i;
    reg  [31:0] s_wdata = 32'h0;
    reg  [3:0]  kbi_rising = 4'h0;
    reg  [4:0]  tpm2_ch_en;
    reg  [2:0]  tpm1_ch_en;
    reg  [55:0] periph_oe = 56'h0, periph_out = 56'h0;
    wire        s_bready = 1'b1, s_rready = 1'b1;
    wire [3:0]  s_wstrb = 4'hf;
    wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq_request, irq_pull_up, irq_pull_down;
    wire [1:0]  s_bresp, s_rresp;
    wire [31:0] s_rdata;
    wire [55:0] periph_in, pin_in, pin_out, pin_oe, pull_up, pull_down;
    integer     failures = 0, n_tests = 0;
    pin_port_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .kbi_pin_en(kbi_pin_en), .kbi_rising(kbi_rising), .adc_pin_en(adc_pin_en), .iic_en(iic_en),
        .sci2_en(sci2_en), .tpm2_ch_en(tpm2_ch_en), .tpm1_ch_en(tpm1_ch_en), .spi_en(spi_en), .sci1_en(sci1_en),
        .osc_en(osc_en), .debug_en(debug_en), .periph_oe(periph_oe), .periph_out(periph_out),
        .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up),
        .pull_down(pull_down), .irq_pin(irq_pin), .irq_request(irq_request), .irq_pull_up(irq_pull_up),
        .irq_pull_down(irq_pull_down));
    pad_model pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pull_down(pull_down),
        .pin_in(pin_in));
    always #5 aclk = ~aclk;
    task miss(input [191:0] g, input [191:0] w);
        begin
            failures = failures + 1;
            $display("ERROR %0t: got %h want %h", $time, g, w);
        end
    endtask
    task complete_run;
        begin
            if (failures == 0 && n_tests > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task own(input [29:0] v);
        {debug_en, osc_en, sci1_en, spi_en, tpm1_ch_en, tpm2_ch_en, sci2_en, iic_en, adc_pin_en, kbi_pin_en} <= v;
    endtask
    task settle;
        repeat (4) @(posedge aclk);
    endtask
    task rst;
        begin
            aresetn <= 1'b0;
            repeat (6) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
        end
    endtask
    // bready stays high, so bvalid seen is the handshake
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        reg aw, w, b;
        begin
            {aw, w, b} = 3'b110;
            s_awaddr <= a;
            s_wdata <= d;
            {s_awvalid, s_wvalid} <= 2'b11;
            while (!b) begin
                @(posedge aclk);
                // valid drops by nba so the design still sees it at this edge
                if (aw && s_awready) begin
                    aw = 1'b0;
                    s_awvalid <= 1'b0;
                end
                if (w && s_wready) begin
                    w = 1'b0;
                    s_wvalid <= 1'b0;
                end
                b = s_bvalid;
            end
            `CHK(s_bresp, r)
        end
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        begin
            s_araddr <= a;
            s_arvalid <= 1'b1;
            @(posedge aclk);
            while (!s_arready) @(posedge aclk);
            s_arvalid <= 1'b0;
            @(posedge aclk);
            while (!s_rvalid) @(posedge aclk);
            `CHK(s_rresp, r)
            if (r == `RESP_OKAY) `CHK(s_rdata, d)
        end
    endtask
    // a full run is under 3000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures = failures + 1;
        complete_run;
    end
    initial begin
        own(30'h0);
        rst;
        // plain port c: output, then mixed with pulls
        wr(8'h24, 32'hff, `RESP_OKAY);
        wr(8'h20, 32'ha5, `RESP_OKAY);
        settle;
        `CHK({pin_oe[23:16], pin_out[23:16]}, 16'hffa5)
        rd(8'h20, 32'ha5, `RESP_OKAY);
        wr(8'h24, 32'h0f, `RESP_OKAY);
        wr(8'h28, 32'hf0, `RESP_OKAY);
        settle;
        `CHK(pull_up[23:16], 8'hf0)
        rd(8'h20, 32'hf5, `RESP_OKAY);
        wr(8'h2c, 32'h0, `RESP_OKAY);
        rd(8'h2c, 32'hf5, `RESP_OKAY);
        // keyboard owns port a, mixed polarity
        periph_oe <= 56'h0f;
        periph_out <= 56'h05;
        kbi_rising <= 4'h5;
        own(30'hff);
        settle;
        `CHK({pin_oe[7:0], pin_out[3:0]}, 12'h0f5)
        `CHK({pull_down[7:0], pull_up[7:0]}, 16'h50a0)
        rd(8'h00, 32'ha5, `RESP_OKAY);
        wr(8'h00, 32'h3c, `RESP_OKAY);
        wr(8'h04, 32'hff, `RESP_OKAY);
        settle;
        rd(8'h00, 32'h3c, `RESP_OKAY);
        `CHK(pin_oe[7:0], 8'h0f)
        // every peripheral claims its pins at once
        wr(8'h24, 32'h0, `RESP_OKAY);
        periph_oe <= {56{1'b1}};
        own(30'h3fffffff);
        settle;
        `CHK(pin_oe, 56'h07003fff0fffff)
        own(30'h0);
        settle;
        `CHK(pin_oe, 56'hff)
        // converter owns port b as inputs, pull bits still apply
        periph_oe <= 56'h0;
        own(30'hff00);
        wr(8'h18, 32'h3c, `RESP_OKAY);
        settle;
        `CHK(pull_up[15:8], 8'h3c)
        // irq pin: disabled, falling, rising
        irq_pin <= 1'b1;
        settle;
        `CHK({irq_request, irq_pull_up, irq_pull_down}, 3'b000)
        wr(`ADDR_IRQ_CTRL, 32'h1, `RESP_OKAY);
        settle;
        `CHK({irq_request, irq_pull_up, irq_pull_down}, 3'b110)
        wr(`ADDR_IRQ_CTRL, 32'h7, `RESP_OKAY);
        settle;
        `CHK({irq_pull_up, irq_pull_down}, 2'b01)
        rd(`ADDR_IRQ_CTRL, 32'h7, `RESP_OKAY);
        rd(`ADDR_IRQ_STAT, 32'h1, `RESP_OKAY);
        wr(8'h80, 32'h1, `RESP_DECERR);
        rd(8'h80, 32'h0, `RESP_DECERR);
        // second reset clears everything written
        rst;
        `CHK({pin_oe, pull_up, pull_down, irq_pull_up, irq_pull_down, irq_request}, 171'h0)
        for (i = 8'h0; i < 8'h7; i = i + 8'h1) begin
            rd(i * 8'h10 + 8'h4, 32'h0, `RESP_OKAY);
            rd(i * 8'h10 + 8'h8, 32'h0, `RESP_OKAY);
        end
        rd(`ADDR_IRQ_CTRL, 32'h0, `RESP_OKAY);
        complete_run;
    end
endmodule

/* core/pin_cell.v */
/*
 * one shared pin: output buffer ownership, pull selection and a
 * two-stage synchroniser for the pad level.
 * assumes control inputs come from logic on aclk; pin_in is asynchronous.
 */
`timescale 1ns/1ps
module pin_cell (
    input  wire aclk,          // bus clock
    input  wire aresetn,       // synchronous reset, active low
    input  wire owner,         // peripheral owns the pin
    input  wire periph_oe,     // peripheral output buffer enable
    input  wire periph_out,    // peripheral output level
    input  wire dir,           // port direction, 1 = output
    input  wire data,          // port data latch
    input  wire pull_en,       // pull enable bit
    input  wire pull_force,    // peripheral forces the pull on
    input  wire pull_down_sel, // pull acts downward
    input  wire pin_in,        // raw pad level
    output reg  pin_out,       // pad output level
    output reg  pin_oe,        // pad output enable
    output reg  pull_up,       // pullup device on
    output reg  pull_down,     // pulldown device on
    output reg  pin_sync       // synchronised pad level
);
    reg  meta;
    wire oe_sel;
    wire pull_on;

    assign oe_sel  = owner ? periph_oe : dir;
    assign pull_on = (pull_en | pull_force) & ~oe_sel;

    // outputs registered so the pad sees no decode glitches
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
            pull_up   <= 1'b0;
            pull_down <= 1'b0;
            meta      <= 1'b0;
            pin_sync  <= 1'b0;
        end else begin
            pin_out   <= owner ? periph_out : data;
            pin_oe    <= oe_sel;
            pull_up   <= pull_on & ~pull_down_sel;
            pull_down <= pull_on & pull_down_sel;
            meta      <= pin_in;
            pin_sync  <= meta;
        end
    end
endmodule

/* core/pin_port_ctrl.v */
/*
 * shared pin port control: direction, data and pull registers per port,
 * peripheral ownership of pins and irq pin pull selection, on axi4-lite.
 * assumes peripheral enables and buffer controls arrive on aclk; pads
 * and the irq pin are asynchronous and are synchronised here.
 */
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
// Summary of operation
// - reset: all pins hi-z inputs, pulls off
// - owning peripheral drives output buffer enable
// - direction bit selects port data readback
// - pull enable applies whenever pin inputs
// - upper keyboard pins rising: pulldown instead
// - irq rising edge: pull enable pulls down (code ignores IRQ_PULL_BIT, pulldown on whenever enabled rising)
// - irq function inactive unless enabled
// - irq falling edge forces pullup on
// - keyboard falling forces pullup, rising pulldown
`timescale 1ns/1ps
`include "pin_port_defs.vh"
module pin_port_ctrl #(
    parameter NPIN = `PIN_COUNT
) (
    input  wire            aclk,          // bus clock, 100 MHz
    input  wire            aresetn,       // synchronous reset, active low
    input  wire [7:0]      s_awaddr,      // write address
    input  wire            s_awvalid,     // write address valid
    output reg             s_awready,     // write address ready
    input  wire [31:0]     s_wdata,       // write data
    input  wire [3:0]      s_wstrb,       // write strobes
    input  wire            s_wvalid,      // write data valid
    output reg             s_wready,      // write data ready
    output reg  [1:0]      s_bresp,       // write response
    output reg             s_bvalid,      // write response valid
    input  wire            s_bready,      // write response ready
    input  wire [7:0]      s_araddr,      // read address
    input  wire            s_arvalid,     // read address valid
    output reg             s_arready,     // read address ready
    output reg  [31:0]     s_rdata,       // read data
    output reg  [1:0]      s_rresp,       // read response
    output reg             s_rvalid,      // read data valid
    input  wire            s_rready,      // read data ready
    input  wire [7:0]      kbi_pin_en,    // keyboard owns port a pins
    input  wire [3:0]      kbi_rising,    // upper keyboard pins rising/high
    input  wire [7:0]      adc_pin_en,    // converter owns port b pins
    input  wire            iic_en,        // two-wire bus enabled
    input  wire            sci2_en,       // second serial link enabled
    input  wire [4:0]      tpm2_ch_en,    // timer2 channels enabled
    input  wire [2:0]      tpm1_ch_en,    // timer1 channels enabled
    input  wire            spi_en,        // serial peripheral enabled
    input  wire            sci1_en,       // first serial link enabled
    input  wire            osc_en,        // oscillator owns its pins
    input  wire            debug_en,      // debug owns mode select pin
    input  wire [NPIN-1:0] periph_oe,     // peripheral buffer enables
    input  wire [NPIN-1:0] periph_out,    // peripheral output levels
    output wire [NPIN-1:0] periph_in,     // synchronised pad levels
    input  wire [NPIN-1:0] pin_in,        // raw pad levels
    output wire [NPIN-1:0] pin_out,       // pad output levels
    output wire [NPIN-1:0] pin_oe,        // pad output enables
    output wire [NPIN-1:0] pull_up,       // pullup devices on
    output wire [NPIN-1:0] pull_down,     // pulldown devices on
    input  wire            irq_pin,       // raw irq pad level
    output reg             irq_request,   // gated irq level to core
    output reg             irq_pull_up,   // irq pullup on
    output reg             irq_pull_down  // irq pulldown on
);
    reg  [NPIN-1:0] port_data;
    reg  [NPIN-1:0] port_dir;
    reg  [NPIN-1:0] port_pull;
    reg  [2:0]      irq_ctrl;
    reg             irq_meta;
    reg             irq_sync;
    reg  [7:0]      aw_addr;
    reg  [7:0]      w_byte;
    reg             w_lane0;
    reg             aw_got;
    reg             w_got;
    reg             next_aw_got;
    reg             next_w_got;
    reg             next_bvalid;
    reg             do_write;
    reg  [31:0]     rd_word;
    reg             rd_hit;
    reg  [NPIN-1:0] owner;
    reg  [NPIN-1:0] pull_force;
    reg  [NPIN-1:0] pull_down_sel;
    wire [NPIN-1:0] port_read;
    wire [2:0]      wr_port;
    wire [1:0]      wr_sel;
    wire [2:0]      rd_port;
    wire [1:0]      rd_sel;

    always @* begin
        owner          = {NPIN{1'b0}};
        owner[7:0]     = kbi_pin_en;
        owner[15:8]    = adc_pin_en;
        owner[17:16]   = {2{sci2_en}};
        owner[19:18]   = {2{iic_en}};
        owner[26:24]   = tpm1_ch_en;
        owner[31:27]   = tpm2_ch_en;
        owner[33:32]   = {2{sci1_en}};
        owner[37:34]   = {4{spi_en}};
        owner[48]      = debug_en;
        owner[50:49]   = {2{osc_en}};
    end

    // keyboard pins get forced pulls; only the upper four can pick rising
    always @* begin
        pull_force    = {NPIN{1'b0}};
        pull_down_sel = {NPIN{1'b0}};
        pull_force[7:0] = kbi_pin_en;
        pull_down_sel[7:4] = kbi_pin_en[7:4] & kbi_rising;
    end

    assign port_read = (port_dir & port_data) | (~port_dir & periph_in);

    // one cell per pin
    genvar i;
    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_pin
            pin_cell u_cell (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .owner         (owner[i]),
                .periph_oe     (periph_oe[i]),
                .periph_out    (periph_out[i]),
                .dir           (port_dir[i]),
                .data          (port_data[i]),
                .pull_en       (port_pull[i]),
                .pull_force    (pull_force[i]),
                .pull_down_sel (pull_down_sel[i]),
                .pin_in        (pin_in[i]),
                .pin_out       (pin_out[i]),
                .pin_oe        (pin_oe[i]),
                .pull_up       (pull_up[i]),
                .pull_down     (pull_down[i]),
                .pin_sync      (periph_in[i])
            );
        end
    endgenerate

    // irq pad synchroniser and pull choice
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_meta      <= 1'b0;
            irq_sync      <= 1'b0;
            irq_request   <= 1'b0;
            irq_pull_up   <= 1'b0;
            irq_pull_down <= 1'b0;
        end else begin
            irq_meta      <= irq_pin;
            irq_sync      <= irq_meta;
            irq_request   <= irq_sync & irq_ctrl[`IRQ_EN_BIT];
            irq_pull_up   <= irq_ctrl[`IRQ_EN_BIT] & ~irq_ctrl[`IRQ_RISE_BIT];
            irq_pull_down <= irq_ctrl[`IRQ_EN_BIT] & irq_ctrl[`IRQ_RISE_BIT];
        end
    end

    // write channel: address and data taken in either order
    assign wr_port = aw_addr[6:4];
    assign wr_sel  = aw_addr[3:2];
    always @* begin
        do_write    = aw_got & w_got & ~s_bvalid;
        next_aw_got = (aw_got | (s_awvalid & s_awready)) & ~do_write;
        next_w_got  = (w_got | (s_wvalid & s_wready)) & ~do_write;
        next_bvalid = do_write | (s_bvalid & ~s_bready);
    end

    // bus write side and register stores
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `RESP_OKAY;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= 8'h00;
            w_byte    <= 8'h00;
            w_lane0   <= 1'b0;
            port_data <= {`PORT_COUNT{`RST_DATA}};
            port_dir  <= {`PORT_COUNT{`RST_DIR}};
            port_pull <= {`PORT_COUNT{`RST_PULL}};
            irq_ctrl  <= `RST_IRQ_CTRL;
        end else begin
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            s_bvalid  <= next_bvalid;
            s_awready <= ~next_aw_got & ~next_bvalid;
            s_wready  <= ~next_w_got & ~next_bvalid;
            if (s_awvalid && s_awready) begin
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_byte  <= s_wdata[7:0];
                w_lane0 <= s_wstrb[0];
            end
            if (do_write) begin
                s_bresp <= `RESP_OKAY;
                if (aw_addr == `ADDR_IRQ_CTRL) begin
                    if (w_lane0) begin
                        irq_ctrl <= w_byte[2:0];
                    end
                end else if (aw_addr == `ADDR_IRQ_STAT) begin
                    s_bresp <= `RESP_OKAY;
                end else if (wr_port < `PORT_COUNT && aw_addr[7] == 1'b0 && aw_addr[1:0] == 2'b00) begin
                    // input register is read-only, writes to it are dropped
                    if (w_lane0 && wr_sel == `OFS_DATA) begin
                        port_data[wr_port*8 +: 8] <= w_byte;
                    end else if (w_lane0 && wr_sel == `OFS_DIR) begin
                        port_dir[wr_port*8 +: 8] <= w_byte;
                    end else if (w_lane0 && wr_sel == `OFS_PULL) begin
                        port_pull[wr_port*8 +: 8] <= w_byte;
                    end
                end else begin
                    s_bresp <= `RESP_DECERR;
                end
            end
        end
    end

    // read decode
    assign rd_port = s_araddr[6:4];
    assign rd_sel  = s_araddr[3:2];
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_araddr == `ADDR_IRQ_CTRL) begin
            rd_word[2:0] = irq_ctrl;
        end else if (s_araddr == `ADDR_IRQ_STAT) begin
            rd_word[0] = irq_sync;
        end else if (rd_port < `PORT_COUNT && s_araddr[7] == 1'b0 && s_araddr[1:0] == 2'b00) begin
            if (rd_sel == `OFS_DATA) begin
                rd_word[7:0] = port_read[rd_port*8 +: 8];
            end else if (rd_sel == `OFS_DIR) begin
                rd_word[7:0] = port_dir[rd_port*8 +: 8];
            end else if (rd_sel == `OFS_PULL) begin
                rd_word[7:0] = port_pull[rd_port*8 +: 8];
            end else begin
                rd_word[7:0] = periph_in[rd_port*8 +: 8];
            end
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read channel: one read outstanding, arready drops while rvalid
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `RESP_OKAY;
        end else begin
            if (s_arvalid && s_arready) begin
                s_rvalid  <= 1'b1;
                s_arready <= 1'b0;
                s_rdata   <= rd_word;
                s_rresp   <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end else if (!s_rvalid) begin
                s_arready <= 1'b1;
            end
        end
    end
endmodule

/* shared/pin_port_defs.vh */
/*
 * constants for the shared pin port control block: register offsets,
 * field positions, reset values and bus answers.
 * assumes inclusion by bare name from the core files.
 */
`ifndef PIN_PORT_DEFS_VH
`define PIN_PORT_DEFS_VH

// port geometry
`define PORT_COUNT        7
`define PORT_WIDTH        8
`define PIN_COUNT         56

// per-port register block, port n sits at n * stride
`define PORT_STRIDE       8'h10
`define OFS_DATA          2'h0
`define OFS_DIR           2'h1
`define OFS_PULL          2'h2
`define OFS_INPUT         2'h3

// irq pin control and status
`define ADDR_IRQ_CTRL     8'h70
`define ADDR_IRQ_STAT     8'h74
`define IRQ_EN_BIT        0
`define IRQ_RISE_BIT      1
`define IRQ_PULL_BIT      2

// reset values: inputs, no pulls, data cleared
`define RST_DATA          8'h00
`define RST_DIR           8'h00
`define RST_PULL          8'h00
`define RST_IRQ_CTRL      3'h0

// bus answers
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif
